/* pkg/cam_pkg.sv */
package cam_pkg;

    // Bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // Prebyte codes
    localparam logic [7:0] PREBYTE_Y = 8'h90;
    localparam logic [7:0] PREBYTE_IND = 8'h92;

    // Address range limits
    localparam logic [15:0] ZP_TOP = 16'h00ff;
    localparam logic [15:0] SHORT_IDX_TOP = 16'h01fe;
    localparam logic [15:0] ONE = 16'h0001;
    localparam logic [7:0] ZP_PAGE = 8'h00;

    // Interrupt mask levels; reset leaves interrupts masked
    localparam logic [1:0] MASK_LEVEL_SET = 2'h3;
    localparam logic [1:0] MASK_LEVEL_CLR = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h3;

    // Read sequencing phases: issue, strobe high, capture
    localparam logic [1:0] PH_ISSUE = 2'h0;
    localparam logic [1:0] PH_CAPTURE = 2'h2;

    // Addressing modes as seen after prebyte remapping
    typedef enum logic [3:0] {
        M_IMP, M_IMM, M_DIR_S, M_DIR_L, M_IDX_0, M_IDX_S, M_IDX_L,
        M_IND_S, M_IND_L, M_INDX_S, M_INDX_L, M_REL_D, M_REL_I
    } cam_mode_e;

    // Inherent operations with side effects in this block
    typedef enum logic [2:0] {
        INH_OTHER, INH_SET_MASK, INH_CLR_MASK, INH_WAIT, INH_HALT
    } cam_inh_e;

    // Forms that reach the full 64 Kbyte space
    function automatic logic is_long(input cam_mode_e m);
        return (m == M_DIR_L) || (m == M_IDX_L) || (m == M_IND_L) || (m == M_INDX_L);
    endfunction : is_long

    // Modes that read a pointer or offset from memory
    function automatic logic needs_ptr(input cam_mode_e m);
        return (m == M_IND_S) || (m == M_IND_L) || (m == M_INDX_S) ||
               (m == M_INDX_L) || (m == M_REL_I);
    endfunction : needs_ptr

    // Modes whose pointer is a word
    function automatic logic word_ptr(input cam_mode_e m);
        return (m == M_IND_L) || (m == M_INDX_L);
    endfunction : word_ptr

    // Bytes that follow the opcode
    function automatic logic [1:0] bytes_after(input cam_mode_e m);
        logic [1:0] n;
        n = 2'h1;
        if (m == M_IMP || m == M_IDX_0) begin
            n = 2'h0;
        end else if (m == M_DIR_L || m == M_IDX_L) begin
            n = 2'h2;
        end
        return n;
    endfunction : bytes_after

endpackage : cam_pkg

/* hw/cam_prebyte_map.sv */
`timescale 1ns/1ps
module cam_prebyte_map
    import cam_pkg::*;
(
    // Decoded opcode form
    input wire cam_mode_e mode_i,
    input wire logic [7:0] prebyte_i,
    // Resulting form
    output cam_mode_e mode_o,
    output logic use_y_o
);

    // Prebytes only re-route existing forms, so one mapping covers all
    always_comb begin
        mode_o = mode_i;
        use_y_o = 1'b0;
        if (prebyte_i == PREBYTE_Y) begin
            // Y replaces X for immediate, direct, indexed and inherent
            use_y_o = 1'b1;
        end else if (prebyte_i == PREBYTE_IND) begin
            case (mode_i)
                M_DIR_S: mode_o = M_IND_S;
                M_DIR_L: mode_o = M_IND_L;
                M_IDX_S: mode_o = M_INDX_S;
                M_IDX_L: mode_o = M_INDX_L;
                M_REL_D: mode_o = M_REL_I;
                default: mode_o = mode_i;
            endcase
        end
    end

endmodule : cam_prebyte_map

/* hw/cam_ea_adder.sv */
`timescale 1ns/1ps
module cam_ea_adder
    import cam_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Operands, already extended to full width
    input wire logic load_i,
    input wire logic [15:0] base_i,
    input wire logic [15:0] add_i,
    // Registered sum
    output logic [15:0] sum_o
);

    // Full-width sum; a short index plus byte offset never folds back
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sum_o <= 16'h0000;
        end else if (load_i) begin
            sum_o <= base_i + add_i;
        end
    end

endmodule : cam_ea_adder

/* hw/cam_decoder.sv */
`timescale 1ns/1ps
module cam_decoder
    import cam_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Instruction request
    input wire logic start_i,
    input wire cam_mode_e mode_i,
    input wire logic [7:0] prebyte_i,
    input wire logic short_only_i,
    input wire cam_inh_e inh_op_i,
    input wire logic [15:0] pc_i,
    // Index registers
    input wire logic [7:0] x_i,
    input wire logic [7:0] y_i,
    // Memory read port
    output logic mem_rd_o,
    output logic [15:0] mem_addr_o,
    input wire logic [7:0] mem_data_i,
    // Wake-up source
    input wire logic irq_i,
    // Result
    output logic done_o,
    output logic [15:0] ea_o,
    output logic [7:0] operand_o,
    output logic imm_o,
    output logic [1:0] len_o,
    output logic form_err_o,
    // Core state
    output logic [1:0] irq_mask_o,
    output logic wait_o,
    output logic osc_stop_o
);

    typedef enum logic [2:0] {
        S_IDLE, S_OP1, S_OP2, S_PTR1, S_PTR2, S_SUM, S_DONE
    } cam_state_e;

    cam_state_e state; // Sequencer state
    logic [1:0] phase; // Sub-step of a memory read
    cam_mode_e mode_q; // Mode of the current instruction
    logic [7:0] idx_q; // Index value caught at start
    logic [15:0] pc_q; // Opcode address
    logic [15:0] word; // Bytes after the opcode
    logic [15:0] ptr; // Value read through the pointer
    cam_mode_e map_mode; // Mode after prebyte
    logic map_y; // Y selected by prebyte
    logic sleep; // Wait or halt in force
    logic accept; // Request taken this cycle
    logic refuse; // Long form on a short-only class
    logic rd_state; // State that reads memory
    logic [15:0] rd_addr; // Address for the read
    logic [15:0] next_base; // Adder base
    logic [15:0] next_add; // Adder addend
    logic [15:0] sum; // Adder result
    logic [1:0] rd_cnt; // Reads in this instruction, checks only

    // Prebyte remapping of the requested form
    cam_prebyte_map u_map (
        .mode_i(mode_i),
        .prebyte_i(prebyte_i),
        .mode_o(map_mode),
        .use_y_o(map_y)
    );

    // Effective address adder, one cycle of latency
    cam_ea_adder u_add (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .load_i(state == S_SUM),
        .base_i(next_base),
        .add_i(next_add),
        .sum_o(sum)
    );

    // Requests are ignored while the core sleeps
    assign sleep = wait_o | osc_stop_o;
    assign accept = (state == S_IDLE) && start_i && !sleep;
    assign refuse = short_only_i && is_long(map_mode);
    assign rd_state = (state == S_OP1) || (state == S_OP2) ||
                      (state == S_PTR1) || (state == S_PTR2);

    // Read address for each fetch step
    always_comb begin
        rd_addr = pc_q + ONE;
        case (state)
            S_OP2: rd_addr = pc_q + 16'h0002;
            // Pointer address is one byte, so pointers live in page zero
            S_PTR1: rd_addr = {ZP_PAGE, word[7:0]};
            // Word pointer low byte; the byte address wraps within page zero
            S_PTR2: rd_addr = {ZP_PAGE, word[7:0] + 8'h01};
            default: rd_addr = pc_q + ONE;
        endcase
    end

    // Operand selection for the address adder
    always_comb begin
        next_base = word;
        next_add = 16'h0000;
        case (mode_q)
            // Address of the operand byte itself
            M_IMM: next_base = pc_q + ONE;
            M_DIR_S: next_base = word;
            M_DIR_L: next_base = word;
            M_IDX_0: begin
                next_base = 16'h0000;
                next_add = {8'h00, idx_q};
            end
            M_IDX_S, M_IDX_L: begin
                next_base = word;
                next_add = {8'h00, idx_q};
            end
            M_IND_S, M_IND_L: next_base = ptr;
            M_INDX_S, M_INDX_L: begin
                next_base = ptr;
                next_add = {8'h00, idx_q};
            end
            // Offset counts from the end of the instruction
            M_REL_D: begin
                next_base = pc_q + 16'h0002;
                next_add = {{8{word[7]}}, word[7:0]};
            end
            M_REL_I: begin
                next_base = pc_q + 16'h0002;
                next_add = {{8{ptr[7]}}, ptr[7:0]};
            end
            default: next_add = 16'h0000;
        endcase
    end

    // Sequencer: fetch bytes, follow pointer, sum, report
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            phase <= PH_ISSUE;
            mode_q <= M_IMP;
            idx_q <= 8'h00;
            pc_q <= 16'h0000;
            word <= 16'h0000;
            ptr <= 16'h0000;
        end else begin
            case (state)
                S_IDLE: begin
                    if (accept && !refuse) begin
                        mode_q <= map_mode;
                        idx_q <= map_y ? y_i : x_i;
                        pc_q <= pc_i;
                        word <= 16'h0000;
                        ptr <= 16'h0000;
                        phase <= PH_ISSUE;
                        if (map_mode == M_IMP) begin
                            // Opcode alone says it all
                            state <= S_DONE;
                        end else if (map_mode == M_IDX_0) begin
                            state <= S_SUM;
                        end else begin
                            state <= S_OP1;
                        end
                    end
                end
                S_OP1: begin
                    if (phase == PH_CAPTURE) begin
                        phase <= PH_ISSUE;
                        word <= {8'h00, mem_data_i};
                        if (mode_q == M_DIR_L || mode_q == M_IDX_L) begin
                            state <= S_OP2;
                        end else if (needs_ptr(mode_q)) begin
                            state <= S_PTR1;
                        end else begin
                            state <= S_SUM;
                        end
                    end else begin
                        phase <= phase + 2'h1;
                    end
                end
                S_OP2: begin
                    if (phase == PH_CAPTURE) begin
                        // Address word comes high byte first
                        phase <= PH_ISSUE;
                        word <= {word[7:0], mem_data_i};
                        state <= S_SUM;
                    end else begin
                        phase <= phase + 2'h1;
                    end
                end
                S_PTR1: begin
                    if (phase == PH_CAPTURE) begin
                        phase <= PH_ISSUE;
                        if (word_ptr(mode_q)) begin
                            ptr <= {mem_data_i, 8'h00};
                            state <= S_PTR2;
                        end else begin
                            ptr <= {8'h00, mem_data_i};
                            state <= S_SUM;
                        end
                    end else begin
                        phase <= phase + 2'h1;
                    end
                end
                S_PTR2: begin
                    if (phase == PH_CAPTURE) begin
                        phase <= PH_ISSUE;
                        ptr <= {ptr[15:8], mem_data_i};
                        state <= S_SUM;
                    end else begin
                        phase <= phase + 2'h1;
                    end
                end
                S_SUM: state <= S_DONE;
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Memory strobe: one cycle high per byte, data back the cycle after
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            mem_rd_o <= 1'b0;
            mem_addr_o <= 16'h0000;
        end else begin
            mem_rd_o <= rd_state && (phase == PH_ISSUE);
            if (rd_state && (phase == PH_ISSUE)) begin
                mem_addr_o <= rd_addr;
            end
        end
    end

    // Result outputs: done_o pulses one cycle, the rest are held until the next instruction completes
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            done_o <= 1'b0;
            ea_o <= 16'h0000;
            operand_o <= 8'h00;
            imm_o <= 1'b0;
            len_o <= 2'h0;
        end else begin
            done_o <= (state == S_DONE);
            if (state == S_DONE) begin
                ea_o <= (mode_q == M_IMP) ? pc_q : sum;
                // Immediate byte is the value itself
                operand_o <= word[7:0];
                imm_o <= (mode_q == M_IMM);
                len_o <= bytes_after(mode_q);
            end
        end
    end

    // Refusal pulse for a long form on a short-only class
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            form_err_o <= 1'b0;
        end else begin
            form_err_o <= accept && refuse;
        end
    end

    // Interrupt mask level from the mask instructions
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            irq_mask_o <= MASK_RESET;
        end else if (accept && map_mode == M_IMP) begin
            if (inh_op_i == INH_SET_MASK) begin
                irq_mask_o <= MASK_LEVEL_SET;
            end else if (inh_op_i == INH_CLR_MASK) begin
                irq_mask_o <= MASK_LEVEL_CLR;
            end
        end
    end

    // Low-power states; an interrupt is the only way out short of reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wait_o <= 1'b0;
            osc_stop_o <= 1'b0;
        end else if (irq_i) begin
            wait_o <= 1'b0;
            osc_stop_o <= 1'b0;
        end else if (accept && map_mode == M_IMP) begin
            if (inh_op_i == INH_WAIT) begin
                wait_o <= 1'b1;
            end
            if (inh_op_i == INH_HALT) begin
                osc_stop_o <= 1'b1;
            end
        end
    end

    // Read counter used only by the checks below
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rd_cnt <= 2'h0;
        end else if (accept) begin
            rd_cnt <= 2'h0;
        end else if (mem_rd_o) begin
            rd_cnt <= rd_cnt + 2'h1;
        end
    end

    chk_inherent_no_fetch: assert property (@(posedge clock_i) disable iff (rst_i)
        done_o && mode_q == M_IMP |-> rd_cnt == 2'h0 && len_o == 2'h0)
        else $error("inherent instruction fetched operand bytes");

    chk_immediate_one_byte: assert property (@(posedge clock_i) disable iff (rst_i)
        done_o && mode_q == M_IMM |-> rd_cnt == 2'h1 && ea_o == pc_q + ONE)
        else $error("immediate did not fetch exactly one byte");

    chk_short_direct_page: assert property (@(posedge clock_i) disable iff (rst_i)
        done_o && mode_q == M_DIR_S |-> ea_o <= ZP_TOP && rd_cnt == 2'h1)
        else $error("short direct left page zero");

    chk_long_two_bytes: assert property (@(posedge clock_i) disable iff (rst_i)
        done_o && (mode_q == M_DIR_L || mode_q == M_IDX_L) |-> rd_cnt == 2'h2)
        else $error("long form did not fetch two bytes");

    chk_no_offset_index: assert property (@(posedge clock_i) disable iff (rst_i)
        done_o && mode_q == M_IDX_0 |-> ea_o == {8'h00, idx_q} && rd_cnt == 2'h0)
        else $error("no-offset indexed address wrong");

    chk_short_index_range: assert property (@(posedge clock_i) disable iff (rst_i)
        done_o && (mode_q == M_IDX_S || mode_q == M_INDX_S) |-> ea_o <= SHORT_IDX_TOP)
        else $error("short indexed result beyond 1FE");

    chk_word_pointer_reads: assert property (@(posedge clock_i) disable iff (rst_i)
        done_o && word_ptr(mode_q) |-> rd_cnt == 2'h3)
        else $error("word pointer not read as two bytes");

    chk_long_form_refused: assert property (@(posedge clock_i) disable iff (rst_i)
        accept && refuse |=> form_err_o && state == S_IDLE ##1 !done_o)
        else $error("long form accepted on short-only class");

    chk_mask_levels: assert property (@(posedge clock_i) disable iff (rst_i)
        accept && map_mode == M_IMP && inh_op_i == INH_SET_MASK
        |=> irq_mask_o == MASK_LEVEL_SET)
        else $error("set-mask did not reach level 3");

    chk_wake_on_irq: assert property (@(posedge clock_i) disable iff (rst_i)
        (wait_o || osc_stop_o) && irq_i |=> !wait_o && !osc_stop_o)
        else $error("interrupt did not end low-power state");

endmodule : cam_decoder

/* sim/cam_mem_model.sv */
`timescale 1ns/1ps
module cam_mem_model (
    // Clock
    input wire logic clock_i,
    // Read port of the decoder
    input wire logic mem_rd_i,
    input wire logic [15:0] mem_addr_i,
    output logic [7:0] mem_data_o
);
    // Program and data store, loaded by the bench before the requests that read it
    logic [7:0] mem [0:65535];
    // Data register, toggled between reads; seeded so the idle pattern is never unknown
    logic [7:0] data = 8'h5a;

    // Answer exactly one cycle after the strobe
    always @(posedge clock_i) begin
        if (mem_rd_i) begin
            data <= mem[mem_addr_i];
        end else begin
            // Released bus toggles, so a late capture reads garbage, not a stale byte
            data <= ~data;
        end
    end

    assign mem_data_o = data;
endmodule : cam_mem_model

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
    import cam_pkg::*;
    // Request side
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i = 1'b0;
    cam_mode_e mode_i = M_IMP;
    logic [7:0] prebyte_i = 8'h00;
    logic short_only_i = 1'b0;
    cam_inh_e inh_op_i = INH_OTHER;
    logic [15:0] pc_i = 16'h0000;
    logic [7:0] x_i = 8'h00;
    logic [7:0] y_i = 8'h00;
    logic irq_i = 1'b0;
    // Memory port and results
    logic mem_rd_o, done_o, imm_o, form_err_o, wait_o, osc_stop_o;
    logic [15:0] mem_addr_o, ea_o;
    logic [7:0] mem_data_i, operand_o;
    logic [1:0] len_o, irq_mask_o;
    // Score
    int n_fail = 0;
    int total_checks = 0;

    cam_decoder i_dut (.clock_i(clock_i), .rst_i(rst_i), .start_i(start_i),
        .mode_i(mode_i), .prebyte_i(prebyte_i), .short_only_i(short_only_i),
        .inh_op_i(inh_op_i), .pc_i(pc_i), .x_i(x_i), .y_i(y_i), .mem_rd_o(mem_rd_o),
        .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i), .irq_i(irq_i),
        .done_o(done_o), .ea_o(ea_o), .operand_o(operand_o), .imm_o(imm_o),
        .len_o(len_o), .form_err_o(form_err_o), .irq_mask_o(irq_mask_o),
        .wait_o(wait_o), .osc_stop_o(osc_stop_o));

    cam_mem_model i_mem (.clock_i(clock_i), .mem_rd_i(mem_rd_o),
        .mem_addr_i(mem_addr_o), .mem_data_o(mem_data_i));

    // 40 MHz clock
    initial begin
        forever #12.5 clock_i = ~clock_i;
    end

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic put(input logic [15:0] a, input logic [7:0] v);
        i_mem.mem[a] = v;
    endtask : put

    // One request; lat counts edges from taking to done or refusal
    task automatic run(input cam_mode_e m, input logic [7:0] pb, input logic so,
                       input cam_inh_e io, input logic [15:0] pc, output logic [15:0] lat);
        // Let an edge pass so start_i never rises in the step another task lowered it
        @(posedge clock_i);
        #2 mode_i = m;
        prebyte_i = pb;
        short_only_i = so;
        inh_op_i = io;
        pc_i = pc;
        start_i = 1'b1;
        @(posedge clock_i);
        #2 start_i = 1'b0;
        // The taking edge counts as the first, so a refusal pulse is seen at once
        lat = 16'h0001;
        // Bounded wait so a lost answer cannot hang the run
        while (done_o !== 1'b1 && form_err_o !== 1'b1 && lat < 16'h0014) begin
            @(posedge clock_i);
            #2 lat++;
        end
    endtask : run

    // Addressed request with the usual three comparisons
    task automatic go(input cam_mode_e m, input logic [7:0] pb, input logic [15:0] pc,
                      input logic [15:0] ea, input logic [15:0] lat, input logic [1:0] len);
        logic [15:0] n;
        run(m, pb, 1'b0, INH_OTHER, pc, n);
        check(n, lat);
        check(ea_o, ea);
        check({14'h0, len_o}, {14'h0, len});
    endtask : go

    // Reset leaves the core masked and idle
    task automatic t_reset();
        check({10'h0, irq_mask_o, wait_o, osc_stop_o, done_o, form_err_o}, 16'h0030);
    endtask : t_reset

    // Mask instructions: one byte, no fetch
    task automatic t_inherent();
        logic [15:0] n;
        run(M_IMP, 8'h00, 1'b0, INH_CLR_MASK, 16'h0200, n);
        check(n, 16'h0002);
        check({14'h0, len_o}, 16'h0000);
        check({14'h0, irq_mask_o}, 16'h0000);
        run(M_IMP, 8'h00, 1'b0, INH_SET_MASK, 16'h0200, n);
        check({14'h0, irq_mask_o}, 16'h0003);
    endtask : t_inherent

    // Wait and halt: requests ignored until an interrupt
    task automatic t_sleep();
        logic [15:0] n;
        logic seen;
        for (int k = 0; k < 2; k++) begin
            run(M_IMP, 8'h00, 1'b0, (k == 1) ? INH_HALT : INH_WAIT, 16'h0200, n);
            check({15'h0, (k == 1) ? osc_stop_o : wait_o}, 16'h0001);
            seen = 1'b0;
            start_i = 1'b1;
            repeat (4) begin
                @(posedge clock_i);
                #2 seen = seen | done_o | mem_rd_o;
            end
            check({15'h0, seen}, 16'h0000);
            start_i = 1'b0;
            irq_i = 1'b1;
            @(posedge clock_i);
            #2 irq_i = 1'b0;
            check({14'h0, wait_o, osc_stop_o}, 16'h0000);
        end
    endtask : t_sleep

    // Operand byte taken as the value itself
    task automatic t_immediate();
        logic [15:0] n;
        put(16'h0301, 8'h55);
        run(M_IMM, 8'h00, 1'b0, INH_OTHER, 16'h0300, n);
        check(n, 16'h0006);
        check({8'h0, operand_o}, 16'h0055);
        check({15'h0, imm_o}, 16'h0001);
        check({14'h0, len_o}, 16'h0001);
    endtask : t_immediate

    // Short and long direct, big-endian word
    task automatic t_direct();
        put(16'h0401, 8'hab);
        go(M_DIR_S, 8'h00, 16'h0400, 16'h00ab, 16'h0006, 2'h1);
        put(16'h0501, 8'h12);
        put(16'h0502, 8'h34);
        go(M_DIR_L, 8'h00, 16'h0500, 16'h1234, 16'h0009, 2'h2);
    endtask : t_direct

    // Index arithmetic at the range edges, X and Y
    task automatic t_indexed();
        x_i = 8'hf0;
        y_i = 8'h0e;
        go(M_IDX_0, 8'h00, 16'h0600, 16'h00f0, 16'h0003, 2'h0);
        go(M_IDX_0, PREBYTE_Y, 16'h0600, 16'h000e, 16'h0003, 2'h0);
        x_i = 8'hff;
        put(16'h0701, 8'hff);
        go(M_IDX_S, 8'h00, 16'h0700, 16'h01fe, 16'h0006, 2'h1);
        go(M_IDX_S, PREBYTE_Y, 16'h0700, 16'h010d, 16'h0006, 2'h1);
        x_i = 8'h20;
        put(16'h0801, 8'hff);
        put(16'h0802, 8'hf0);
        go(M_IDX_L, 8'h00, 16'h0800, 16'h0010, 16'h0009, 2'h2);
    endtask : t_indexed

    // Pointers read from page zero, byte and word
    task automatic t_indirect();
        put(16'h0901, 8'h40);
        put(16'h0040, 8'h77);
        go(M_IND_S, 8'h00, 16'h0900, 16'h0077, 16'h0009, 2'h1);
        go(M_DIR_S, PREBYTE_IND, 16'h0900, 16'h0077, 16'h0009, 2'h1);
        put(16'h0a01, 8'h41);
        put(16'h0041, 8'hbe);
        put(16'h0042, 8'hef);
        go(M_IND_L, 8'h00, 16'h0a00, 16'hbeef, 16'h000c, 2'h1);
        x_i = 8'hff;
        put(16'h0b01, 8'h60);
        put(16'h0060, 8'hff);
        go(M_INDX_S, 8'h00, 16'h0b00, 16'h01fe, 16'h0009, 2'h1);
        go(M_IDX_S, PREBYTE_IND, 16'h0b00, 16'h01fe, 16'h0009, 2'h1);
        go(M_INDX_L, 8'h00, 16'h0a00, 16'hbfee, 16'h000c, 2'h1);
    endtask : t_indirect

    // Signed offset, negative bound and from memory
    task automatic t_relative();
        put(16'h1001, 8'h80);
        go(M_REL_D, 8'h00, 16'h1000, 16'h0f82, 16'h0006, 2'h1);
        put(16'h1101, 8'h50);
        put(16'h0050, 8'h7f);
        go(M_REL_I, 8'h00, 16'h1100, 16'h1181, 16'h0009, 2'h1);
        go(M_REL_D, PREBYTE_IND, 16'h1100, 16'h1181, 16'h0009, 2'h1);
    endtask : t_relative

    // Short-only classes refuse every long form but keep short ones
    task automatic t_forms();
        cam_mode_e lm [4] = '{M_DIR_L, M_IDX_L, M_IND_L, M_INDX_L};
        logic [15:0] n;
        for (int k = 0; k < 4; k++) begin
            run(lm[k], 8'h00, 1'b1, INH_OTHER, 16'h0500, n);
            check(n, 16'h0001);
            check({15'h0, form_err_o}, 16'h0001);
        end
        run(M_DIR_S, 8'h00, 1'b1, INH_OTHER, 16'h0400, n);
        check(n, 16'h0006);
        check(ea_o, 16'h00ab);
    endtask : t_forms

    // Verdict and end of run
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // Main sequence; reset held for 12 cycles
    initial begin
        repeat (12) @(posedge clock_i);
        #2 rst_i = 1'b0;
        t_reset();
        t_inherent();
        t_sleep();
        t_immediate();
        t_direct();
        t_indexed();
        t_indirect();
        t_relative();
        t_forms();
        complete_run();
    end

    // Watchdog: the run needs well under 1000 cycles
    initial begin
        #50000;
        n_fail++;
        complete_run();
    end
endmodule : tb
